// >>> common/ilp_pkg.sv
package ilp_pkg;
    // Clock and oscillator settling time
    localparam int unsigned CLK_NS = 50;
    localparam int unsigned STAB_NS = 100000;
    localparam int unsigned STAB_CYC = (STAB_NS + CLK_NS - 1) / CLK_NS;
    // Register indices as printed, byte address is four times index
    localparam logic [11:0] IDX_IOR = 12'h0C8;
    localparam logic [11:0] IDX_ADC = 12'h0D1;
    localparam logic [11:0] IDX_TMR = 12'h0D4;
    localparam logic [11:0] IDX_STAT = 12'h0E0;
    localparam logic [11:0] ADDR_IOR = IDX_IOR << 2;
    localparam logic [11:0] ADDR_ADC = IDX_ADC << 2;
    localparam logic [11:0] ADDR_TMR = IDX_TMR << 2;
    localparam logic [11:0] ADDR_STAT = IDX_STAT << 2;
    // Field positions and reset values
    localparam int unsigned IOR_LES = 6;
    localparam int unsigned IOR_ESB = 5;
    localparam int unsigned IOR_GEN = 4;
    localparam logic [7:0] IOR_USED = 8'h70;
    localparam logic [7:0] IOR_RST = 8'h00;
    localparam int unsigned TMR_MASK = 5;
    localparam int unsigned ADC_MASK = 5;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // Vector addresses
    localparam logic [11:0] VEC_NMI = 12'hFFC;
    localparam logic [11:0] VEC_PA = 12'hFF6;
    localparam logic [11:0] VEC_PB = 12'hFF4;
    localparam logic [11:0] VEC_TMR = 12'hFF2;
    localparam logic [11:0] VEC_ADC = 12'hFF0;

    typedef enum logic [2:0] {SRC_NMI, SRC_PA, SRC_PB, SRC_TMR, SRC_ADC} ilp_src_e;
    typedef enum logic [2:0] {
        MODE_NORM = 3'b001, MODE_IRQ = 3'b010, MODE_NMI = 3'b100
    } ilp_mode_e;
    typedef enum logic [5:0] {
        ST_RUN = 6'b000001, ST_ACC = 6'b000010, ST_VEC = 6'b000100,
        ST_WAIT = 6'b001000, ST_STOP = 6'b010000, ST_STAB = 6'b100000
    } ilp_state_e;

    // From the instruction sequencer
    typedef struct packed {
        logic instrDone;
        logic isWait;
        logic isStop;
        logic isReti;
        logic flagWr;
        logic flagC;
        logic flagZ;
        logic [11:0] pc;
    } ilp_seq_in_s;

    // To the instruction sequencer
    typedef struct packed {
        logic pushPc;
        logic popPc;
        logic loadPc;
        logic [11:0] pushData;
        logic [11:0] vector;
    } ilp_seq_out_s;
endpackage : ilp_pkg

// >>> rtl/ilp_core.sv
// How it works
// - Three carry/zero sets kept, for normal, maskable and non-maskable execution.
// - Accepting an interrupt switches to the interrupt or non-maskable flag set.
// - Current program counter is pushed onto the stack before the vector.
// - After acceptance maskable lines are blocked; the non-maskable request still acts outside its own routine.
// - Acceptance clears the request latch of a serviced pin source; timer and converter flags are left set.
// - Last acceptance step loads the vector address of the serviced source.
// - Return restores the previous flag set and pops the saved counter.
// - Global enable bit at C8h gates all sources except non-maskable.
// - Converter end flag reaches vector 4 only with its mask bit set.
// - Wait halts execution; oscillator and peripheral clock keep running.
// - Leaving wait on an interrupt needs no settling delay.
// - Reset during a low-power state gives an ordinary full reset.
// - Stop halts the oscillator until an external request or reset.
// - Leaving stop inserts an oscillator settling delay before execution.
// - With the watchdog active, stop behaves as wait.
// - Woken from main program: service routine runs, then code after.
// - Woken inside non-maskable routine: resume there, new request not serviced.
// - Woken inside maskable routine by maskable: routine resumes, pending served later.
// - Woken inside maskable routine by non-maskable: that handler runs first.
// - Global enable cleared means no interrupt wakes; only reset restarts.
// - Wait or stop is skipped while an enabled request is pending.
// - Requests are sampled after each instruction and serviced instead of next.
// - Fixed priority vector 1 highest to 4; only non-maskable preempts.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ilp_core import ilp_pkg::*; #(
    parameter int unsigned STAB_CYCLES = STAB_CYC
) (
    input wire logic clk, // Core clock
    input wire logic rstn, // Sync reset, low
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic nmiPinN, // Non-maskable pin
    input wire logic portALineN, // Port A request line
    input wire logic portBLine, // Port B request line
    input wire logic timer_zero_flag, // Timer overflow
    input wire logic convDoneFlag, // Conversion done
    input wire logic wdActive, // Watchdog running
    input wire ilp_seq_in_s seqIn, // From sequencer
    output ilp_seq_out_s seqOut, // To sequencer
    output logic activeC, // Carry in use
    output logic activeZ, // Zero in use
    output logic coreHalt, // Sequencer frozen
    output logic oscRun, // Oscillator on
    output logic periphClkEn // Peripheral clock on
);

    // Settling counter is 16 bits wide
    if (STAB_CYCLES < 1 || STAB_CYCLES > 65535) begin : g_chk
        $error("STAB_CYCLES out of range");
    end

    ilp_state_e stR;
    ilp_mode_e modeR;
    ilp_mode_e nmiRetR;
    ilp_src_e srcR;
    ilp_src_e selSrc;
    logic [15:0] stabCntR;
    logic [7:0] interrupt_option_reg;
    logic timer_irq_mask;
    logic converter_irq_mask;
    logic global_irq_enable;
    logic nmiPrevR, paPrevR, pbPrevR;
    logic nmiLatR, paLatR, pbLatR;
    logic nmiFall, paFall, pbEdge;
    logic [4:1] maskReq;
    logic takeNmi, takeMask, takeReq;
    logic wakeReq, wakeExt;
    logic cR [3];
    logic zR [3];
    logic awHeldR, wHeldR, doWrite, wHit;
    logic [11:0] wAddrR;
    logic [7:0] wDataR;
    logic wStrbR;

    // Flag set index of a mode
    function automatic logic [1:0] modeIdx(input ilp_mode_e m);
        case (m)
            MODE_IRQ: modeIdx = 2'h1;
            MODE_NMI: modeIdx = 2'h2;
            default: modeIdx = 2'h0;
        endcase
    endfunction : modeIdx

    // Vector of a source
    function automatic logic [11:0] vecOf(input ilp_src_e s);
        case (s)
            SRC_PA: vecOf = VEC_PA;
            SRC_PB: vecOf = VEC_PB;
            SRC_TMR: vecOf = VEC_TMR;
            SRC_ADC: vecOf = VEC_ADC;
            default: vecOf = VEC_NMI;
        endcase
    endfunction : vecOf

    assign global_irq_enable = interrupt_option_reg[IOR_GEN];

    // Pin history for edge detection
    always_ff @(posedge clk) begin
        if (!rstn) begin
            nmiPrevR <= 1'b1;
            paPrevR <= 1'b1;
            pbPrevR <= 1'b0;
        end else begin
            nmiPrevR <= nmiPinN;
            paPrevR <= portALineN;
            pbPrevR <= portBLine;
        end
    end

    // Edge events; port B edge chosen by option bit
    assign nmiFall = nmiPrevR & ~nmiPinN;
    assign paFall = paPrevR & ~portALineN;
    assign pbEdge = interrupt_option_reg[IOR_ESB] ? (~pbPrevR & portBLine)
                                                  : (pbPrevR & ~portBLine);

    // Request latches; a new edge wins over the clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            nmiLatR <= 1'b0;
            paLatR <= 1'b0;
            pbLatR <= 1'b0;
        end else begin
            if (stR == ST_ACC && srcR == SRC_NMI) nmiLatR <= 1'b0;
            if (stR == ST_ACC && srcR == SRC_PA) paLatR <= 1'b0;
            if (stR == ST_ACC && srcR == SRC_PB) pbLatR <= 1'b0;
            if (nmiFall) nmiLatR <= 1'b1;
            if (paFall && !interrupt_option_reg[IOR_LES]) paLatR <= 1'b1;
            if (pbEdge) pbLatR <= 1'b1;
        end
    end

    // Maskable requests; level mode on port A has no storage
    assign maskReq[1] = interrupt_option_reg[IOR_LES] ? ~portALineN : paLatR;
    assign maskReq[2] = pbLatR;
    assign maskReq[3] = timer_zero_flag & timer_irq_mask;
    assign maskReq[4] = convDoneFlag & converter_irq_mask;

    // Acceptance: no nesting of maskables, non-maskable preempts
    assign takeNmi = nmiLatR && modeR != MODE_NMI;
    assign takeMask = global_irq_enable && modeR == MODE_NORM && |maskReq;
    assign takeReq = takeNmi || takeMask;

    // Wake needs global enable, even for the non-maskable pin
    assign wakeReq = global_irq_enable && (nmiLatR || |maskReq);
    assign wakeExt = global_irq_enable && (nmiLatR || maskReq[1] || maskReq[2]);

    // Fixed priority select
    always_comb begin
        if (takeNmi) selSrc = SRC_NMI;
        else if (maskReq[1]) selSrc = SRC_PA;
        else if (maskReq[2]) selSrc = SRC_PB;
        else if (maskReq[3]) selSrc = SRC_TMR;
        else selSrc = SRC_ADC;
    end

    // Core sequencing, mode tracking and stack/PC strobes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            stR <= ST_RUN;
            modeR <= MODE_NORM;
            nmiRetR <= MODE_NORM;
            srcR <= SRC_NMI;
            stabCntR <= 16'h0000;
            seqOut <= '0;
        end else begin
            seqOut.pushPc <= 1'b0;
            seqOut.popPc <= 1'b0;
            seqOut.loadPc <= 1'b0;
            case (stR)
                ST_RUN: begin
                    if (seqIn.instrDone) begin
                        if (takeReq) begin
                            stR <= ST_ACC;
                            srcR <= selSrc;
                        end else if (seqIn.isReti) begin
                            seqOut.popPc <= 1'b1;
                            modeR <= (modeR == MODE_NMI) ? nmiRetR : MODE_NORM;
                        end else if ((seqIn.isWait || seqIn.isStop) && wakeReq) begin
                            stR <= ST_RUN;
                        end else if (seqIn.isStop && !wdActive) begin
                            stR <= ST_STOP;
                        end else if (seqIn.isWait || seqIn.isStop) begin
                            stR <= ST_WAIT;
                        end
                    end
                end
                ST_ACC: begin
                    seqOut.pushPc <= 1'b1;
                    seqOut.pushData <= seqIn.pc;
                    if (srcR == SRC_NMI) begin
                        nmiRetR <= modeR;
                        modeR <= MODE_NMI;
                    end else begin
                        modeR <= MODE_IRQ;
                    end
                    stR <= ST_VEC;
                end
                ST_VEC: begin
                    seqOut.loadPc <= 1'b1;
                    seqOut.vector <= vecOf(srcR);
                    stR <= ST_RUN;
                end
                ST_WAIT: begin
                    // Mode decides: serve now, or resume after the wait
                    if (wakeReq && takeReq) begin
                        stR <= ST_ACC;
                        srcR <= selSrc;
                    end else if (wakeReq) begin
                        stR <= ST_RUN;
                    end
                end
                ST_STOP: begin
                    if (wakeExt) begin
                        stR <= ST_STAB;
                        stabCntR <= 16'(STAB_CYCLES - 1);
                    end
                end
                ST_STAB: begin
                    if (stabCntR != 16'h0000) begin
                        stabCntR <= stabCntR - 16'h0001;
                    end else if (takeReq) begin
                        stR <= ST_ACC;
                        srcR <= selSrc;
                    end else begin
                        stR <= ST_RUN;
                    end
                end
                default: stR <= ST_RUN;
            endcase
        end
    end

    // Banked flags, written only in the set that is in use
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < 3; i++) begin
                cR[i] <= 1'b0;
                zR[i] <= 1'b0;
            end
        end else if (seqIn.flagWr && stR == ST_RUN) begin
            cR[modeIdx(modeR)] <= seqIn.flagC;
            zR[modeIdx(modeR)] <= seqIn.flagZ;
        end
    end

    // Flag set follows the mode
    assign activeC = cR[modeIdx(modeR)];
    assign activeZ = zR[modeIdx(modeR)];

    // Power control
    assign coreHalt = stR != ST_RUN;
    assign oscRun = stR != ST_STOP;
    assign periphClkEn = stR != ST_STOP && stR != ST_STAB;

    // Write address and data taken in either order
    assign s_axi_awready = !awHeldR && !s_axi_bvalid;
    assign s_axi_wready = !wHeldR && !s_axi_bvalid;
    assign doWrite = awHeldR && wHeldR && !s_axi_bvalid;
    assign wHit = wAddrR == ADDR_IOR || wAddrR == ADDR_TMR || wAddrR == ADDR_ADC;

    // Write channel handshake
    always_ff @(posedge clk) begin
        if (!rstn) begin
            awHeldR <= 1'b0;
            wHeldR <= 1'b0;
            wAddrR <= 12'h000;
            wDataR <= 8'h00;
            wStrbR <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeldR <= 1'b1;
                wAddrR <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeldR <= 1'b1;
                wDataR <= s_axi_wdata[7:0];
                wStrbR <= s_axi_wstrb[0];
            end
            if (doWrite) begin
                awHeldR <= 1'b0;
                wHeldR <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wHit ? RESP_OK : RESP_ERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register stores, low byte lane only
    always_ff @(posedge clk) begin
        if (!rstn) begin
            interrupt_option_reg <= IOR_RST;
            timer_irq_mask <= 1'b0;
            converter_irq_mask <= 1'b0;
        end else if (doWrite && wStrbR) begin
            if (wAddrR == ADDR_IOR) interrupt_option_reg <= wDataR & IOR_USED;
            if (wAddrR == ADDR_TMR) timer_irq_mask <= wDataR[TMR_MASK];
            if (wAddrR == ADDR_ADC) converter_irq_mask <= wDataR[ADC_MASK];
        end
    end

    // Read channel; option register is write-only and reads zero
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OK;
            case (s_axi_araddr)
                ADDR_IOR: s_axi_rdata <= 32'h00000000;
                ADDR_TMR: s_axi_rdata <= 32'(timer_irq_mask) << TMR_MASK;
                ADDR_ADC: s_axi_rdata <= 32'(converter_irq_mask) << ADC_MASK;
                ADDR_STAT: s_axi_rdata <= {18'h0, nmiLatR, maskReq, modeR, stR};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_ERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Push carries the counter sampled in the acceptance cycle
    property p_push_pc;
        stR == ST_ACC |=> seqOut.pushPc && seqOut.pushData == $past(seqIn.pc);
    endproperty
    a_push_pc: assert property (p_push_pc) else $error("pc not pushed");

    // Vector load comes right after the push
    property p_vec_after_push;
        seqOut.pushPc |=> seqOut.loadPc && seqOut.vector == vecOf($past(srcR, 2));
    endproperty
    a_vec_after_push: assert property (p_vec_after_push) else $error("bad vector");

    // Maskable vector runs in maskable mode
    property p_mask_mode;
        seqOut.loadPc && seqOut.vector != VEC_NMI |-> modeR == MODE_IRQ;
    endproperty
    a_mask_mode: assert property (p_mask_mode) else $error("wrong irq mode");

    // Non-maskable vector runs with its own flag set
    property p_nmi_mode;
        seqOut.loadPc && seqOut.vector == VEC_NMI |-> modeR == MODE_NMI;
    endproperty
    a_nmi_mode: assert property (p_nmi_mode) else $error("wrong nmi mode");

    // No wake while global enable is low
    property p_no_wake;
        stR == ST_WAIT && !global_irq_enable |=> stR == ST_WAIT;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("woke with enable low");

    // Stop only entered with the watchdog idle
    property p_stop_wd;
        stR == ST_STOP && $past(stR) == ST_RUN |-> !$past(wdActive);
    endproperty
    a_stop_wd: assert property (p_stop_wd) else $error("stop with watchdog");

    // Wake from stop loads the full settling count
    property p_stab;
        stR == ST_STOP && wakeExt |=> stR == ST_STAB && stabCntR == 16'(STAB_CYCLES - 1);
    endproperty
    a_stab: assert property (p_stab) else $error("no settling delay");

    // Wait exit takes a single cycle
    property p_wait_exit;
        stR == ST_WAIT && wakeReq |=> stR == ST_RUN || stR == ST_ACC;
    endproperty
    a_wait_exit: assert property (p_wait_exit) else $error("wait exit late");

    // Low-power instruction ignored with a request pending
    property p_skip_wait;
        stR == ST_RUN && seqIn.instrDone && wakeReq |=> stR != ST_WAIT && stR != ST_STOP;
    endproperty
    a_skip_wait: assert property (p_skip_wait) else $error("entered low power");

    // Return from maskable routine restores normal set and pops
    property p_return_from_irq_op;
        stR == ST_RUN && seqIn.instrDone && seqIn.isReti && !takeReq && modeR == MODE_IRQ
            |=> modeR == MODE_NORM && seqOut.popPc;
    endproperty
    a_return_from_irq_op: assert property (p_return_from_irq_op) else $error("return failed");

    c_wait_wake: cover property (stR == ST_WAIT ##1 stR == ST_ACC);
    c_stop_stab: cover property (stR == ST_STAB && stabCntR == 16'h0000);
    c_nmi_nest: cover property (seqOut.loadPc && seqOut.vector == VEC_NMI && nmiRetR == MODE_IRQ);
    c_return_from_irq_op_pop: cover property (seqOut.popPc);

endmodule : ilp_core
`default_nettype wire

// >>> tb/ilp_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module ilp_periph_model (
    input wire logic clk, // Core clock
    input wire logic rstn, // Sync reset, low
    input wire logic [4:0] fire, // Event requests
    input wire logic [1:0] clr, // Flag clears
    output logic nmiPinN, // Non-maskable pin
    output logic portALineN, // Port A line
    output logic portBLine, // Port B line
    output logic timer_zero_flag, // Timer overflow
    output logic convDoneFlag // Conversion done
);
    // Pins idle high on pull-ups and dip low one cycle per event
    always_ff @(posedge clk) begin
        nmiPinN <= !fire[0];
        portALineN <= !fire[1];
        portBLine <= !fire[2];
    end
    // Peripheral flags hold until software clears them
    always_ff @(posedge clk) begin
        if (!rstn) begin
            timer_zero_flag <= 1'b0;
            convDoneFlag <= 1'b0;
        end else begin
            timer_zero_flag <= fire[3] | (timer_zero_flag & !clr[0]);
            convDoneFlag <= fire[4] | (convDoneFlag & !clr[1]);
        end
    end
endmodule : ilp_periph_model
`default_nettype wire

// >>> tb/irq_entry_and_low_power_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module irq_entry_and_low_power_control_tb;
    import ilp_pkg::*;
    localparam int STB = 20;
    logic clk, rstn, awValid, wValid, bReady, arValid, rReady, wdActive, awReady, wReady;
    logic bValid, arReady, rValid, activeC, activeZ, coreHalt, oscRun, clkEn, nmiN, paN, pb, tz, cd;
    logic [11:0] awAddr, arAddr, lastPush, lastVec;
    logic [31:0] wData, rData, d;
    logic [1:0] bResp, rResp, rs, clr;
    logic [4:0] fire;
    ilp_seq_in_s seqIn;
    ilp_seq_out_s seqOut;
    int miscompares, totalChecks, loads, pops, n, l;
    ilp_core #(.STAB_CYCLES(STB)) dut_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(awAddr),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .nmiPinN(nmiN), .portALineN(paN), .portBLine(pb),
        .timer_zero_flag(tz), .convDoneFlag(cd), .wdActive(wdActive), .seqIn(seqIn),
        .seqOut(seqOut), .activeC(activeC), .activeZ(activeZ), .coreHalt(coreHalt),
        .oscRun(oscRun), .periphClkEn(clkEn));
    ilp_periph_model partner_u (.clk(clk), .rstn(rstn), .fire(fire), .clr(clr), .nmiPinN(nmiN),
        .portALineN(paN), .portBLine(pb), .timer_zero_flag(tz), .convDoneFlag(cd));
    // Clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Record sequencer pulses mid-cycle, clear of the edge
    always @(negedge clk) begin
        if (seqOut.pushPc) lastPush = seqOut.pushData;
        if (seqOut.loadPc) begin
            loads++;
            lastVec = seqOut.vector;
        end
        if (seqOut.popPc) pops++;
    end
    task automatic axiWr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw, w, ha, hw, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        @(posedge clk);
        awAddr <= a;
        wData <= v;
        awValid <= 1'b1;
        wValid <= 1'b1;
        for (int i = 0; i < 50 && (aw || w); i++) begin
            @(negedge clk);
            ha = aw && awReady;
            hw = w && wReady;
            @(posedge clk);
            if (ha) awValid <= 1'b0;
            if (hw) wValid <= 1'b0;
            aw = aw && !ha;
            w = w && !hw;
        end
        bReady <= 1'b1;
        for (int i = 0; i < 50 && !b; i++) begin
            @(negedge clk);
            b = bValid;
            r = bResp;
            @(posedge clk);
        end
        bReady <= 1'b0;
    endtask : axiWr
    task automatic axiRd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
        logic h;
        h = 1'b0;
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        for (int i = 0; i < 50 && !h; i++) begin
            @(negedge clk);
            h = arReady;
            @(posedge clk);
        end
        arValid <= 1'b0;
        rReady <= 1'b1;
        h = 1'b0;
        for (int i = 0; i < 50 && !h; i++) begin
            @(negedge clk);
            h = rValid;
            v = rData;
            r = rResp;
            @(posedge clk);
        end
        rReady <= 1'b0;
    endtask : axiRd
    function automatic logic [31:0] sv(logic [3:0] q, ilp_mode_e m, ilp_state_e s);
        return {18'h0, 1'b0, q, m, s};
    endfunction : sv
    task automatic chkStat(input logic [31:0] e);
        axiRd(ADDR_STAT, d, rs);
        `CHK("status", e, d)
    endtask : chkStat
    // One instruction end; k is wait, stop, return
    task automatic instr(input logic [11:0] p, input logic [2:0] k);
        @(posedge clk);
        seqIn.pc <= p;
        {seqIn.isWait, seqIn.isStop, seqIn.isReti} <= k;
        seqIn.instrDone <= 1'b1;
        @(posedge clk);
        seqIn.instrDone <= 1'b0;
        {seqIn.isWait, seqIn.isStop, seqIn.isReti} <= 3'h0;
    endtask : instr
    task automatic pulse(input logic [4:0] v);
        @(posedge clk);
        fire <= v;
        @(posedge clk);
        fire <= 5'h0;
        @(posedge clk);
    endtask : pulse
    task automatic waitLoad();
        l = loads;
        n = 0;
        while (loads == l && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask : waitLoad
    task automatic idle(input int c);
        l = loads;
        repeat (c) @(posedge clk);
        @(negedge clk);
    endtask : idle
    task print_verdict();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
    // Test sequence
    initial begin
        {rstn, awValid, wValid, bReady, arValid, rReady, wdActive} = 7'h0;
        {awAddr, arAddr, wData, seqIn, fire, clr} = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        `CHK("halt", 1'b0, coreHalt)
        chkStat(sv(4'h0, MODE_NORM, ST_RUN));
        axiRd(ADDR_IOR, d, rs);
        `CHK("option", 32'h0, d)
        `CHK("rresp", RESP_OK, rs)
        axiWr(12'h004, 32'h0, rs);
        `CHK("bresp", RESP_ERR, rs)
        $display("test reset done");
        axiWr(ADDR_IOR, 32'h10, rs);
        `CHK("bresp", RESP_OK, rs)
        axiWr(ADDR_TMR, 32'h20, rs);
        axiWr(ADDR_ADC, 32'h20, rs);
        @(posedge clk);
        {seqIn.flagWr, seqIn.flagC, seqIn.flagZ} <= 3'h7;
        @(posedge clk);
        seqIn.flagWr <= 1'b0;
        @(negedge clk);
        `CHK("carry", 1'b1, activeC)
        `CHK("zero", 1'b1, activeZ)
        pulse(5'h1A);
        instr(12'h123, 3'h0);
        waitLoad();
        `CHK("vector", VEC_PA, lastVec)
        `CHK("push", 12'h123, lastPush)
        @(negedge clk);
        `CHK("carry", 1'b0, activeC)
        chkStat(sv(4'hC, MODE_IRQ, ST_RUN));
        instr(12'h124, 3'h0);
        idle(6);
        `CHK("loads", l, loads)
        pulse(5'h01);
        instr(12'h125, 3'h0);
        waitLoad();
        `CHK("vector", VEC_NMI, lastVec)
        chkStat(sv(4'hC, MODE_NMI, ST_RUN));
        instr(12'h300, 3'h1);
        chkStat(sv(4'hC, MODE_IRQ, ST_RUN));
        instr(12'h301, 3'h1);
        idle(2);
        `CHK("pops", 2, pops)
        `CHK("carry", 1'b1, activeC)
        instr(12'h130, 3'h0);
        waitLoad();
        `CHK("vector", VEC_TMR, lastVec)
        clr <= 2'h1;
        axiWr(ADDR_TMR, 32'h0, rs);
        clr <= 2'h0;
        axiWr(ADDR_ADC, 32'h0, rs);
        pulse(5'h08);
        instr(12'h302, 3'h1);
        instr(12'h140, 3'h0);
        idle(6);
        `CHK("loads", l, loads)
        clr <= 2'h3;
        $display("test entry done");
        instr(12'h200, 3'h4);
        clr <= 2'h0;
        idle(2);
        `CHK("halt", 1'b1, coreHalt)
        `CHK("osc", 1'b1, oscRun && clkEn)
        pulse(5'h04);
        waitLoad();
        `CHK("vector", VEC_PB, lastVec)
        `CHK("fast", 1'b1, n < STB)
        instr(12'h303, 3'h1);
        chkStat(sv(4'h0, MODE_NORM, ST_RUN));
        $display("test wait done");
        instr(12'h210, 3'h2);
        idle(2);
        `CHK("osc", 1'b0, oscRun)
        pulse(5'h02);
        waitLoad();
        `CHK("slow", 1'b1, n >= STB)
        instr(12'h304, 3'h1);
        wdActive <= 1'b1;
        instr(12'h220, 3'h2);
        idle(2);
        `CHK("osc", 1'b1, oscRun && coreHalt)
        pulse(5'h02);
        waitLoad();
        `CHK("fast", 1'b1, n < STB)
        instr(12'h305, 3'h1);
        wdActive <= 1'b0;
        $display("test stop done");
        pulse(5'h02);
        instr(12'h230, 3'h4);
        waitLoad();
        `CHK("push", 12'h230, lastPush)
        instr(12'h306, 3'h1);
        $display("test pending done");
        axiWr(ADDR_IOR, 32'h0, rs);
        instr(12'h240, 3'h4);
        pulse(5'h07);
        idle(10);
        `CHK("halt", 1'b1, coreHalt)
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        `CHK("halt", 1'b0, coreHalt)
        chkStat(sv(4'h0, MODE_NORM, ST_RUN));
        $display("test global done");
        print_verdict();
    end
endmodule : irq_entry_and_low_power_control_tb
`default_nettype wire
